// *** design/rswl_top.sv ***
// Reset cause tracking, per-reset register defaults, sleep and pin wake-up
module rswl_top
  import rswl_pkg::*;
#(
  parameter int unsigned WDT_W = 16
) (
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_ext_reset_pin_n,
  input  wire logic                i_undervoltage_reset,
  input  wire logic                i_watchdog_expire,
  input  wire logic                i_slow_osc_tick,
  input  wire logic [7:0]          i_port_pins,
  input  wire logic [ADDR_W-1:0]   i_awaddr,
  input  wire logic                i_awvalid,
  output logic                     o_awready,
  input  wire logic [31:0]         i_wdata,
  input  wire logic [3:0]          i_wstrb,
  input  wire logic                i_wvalid,
  output logic                     o_wready,
  output logic [1:0]               o_bresp,
  output logic                     o_bvalid,
  input  wire logic                i_bready,
  input  wire logic [ADDR_W-1:0]   i_araddr,
  input  wire logic                i_arvalid,
  output logic                     o_arready,
  output logic [31:0]              o_rdata,
  output logic [1:0]               o_rresp,
  output logic                     o_rvalid,
  input  wire logic                i_rready,
  output logic                     o_core_reset,
  output logic                     o_sys_clk_en,
  output logic [7:0]               o_pc_low_byte,
  output logic [2:0]               o_stack_ptr,
  output logic                     o_int_enable,
  output logic                     o_timer_run,
  output logic [WDT_W-1:0]         o_watchdog_counter,
  output logic [7:0]               o_port_data,
  output logic [7:0]               o_port_dir,
  output logic                     o_irq
);
  import rswl_pkg::*;

  localparam logic [4:0] STARTUP_LAST = 5'(STARTUP_WAIT_CYC - 1);
  localparam logic [1:0] SEL_LAST     = 2'(SLOW_OSC_MIN_CYC);

  rswl_mode_e       mode;
  logic             timeout_flag;
  logic             powerdown_flag;
  logic [7:0]       port_wake_enable;
  logic [7:0]       port_data;
  logic [7:0]       port_dir;
  logic [4:0]       pin_sel;
  logic             int_enable;
  logic             timer_run;
  logic [7:0]       prescaler;
  logic [WDT_W-1:0] watchdog_counter;
  logic [7:0]       pc_low_byte;
  logic [2:0]       stack_ptr;
  logic [4:0]       startup_cnt;
  logic [1:0]       sel_bad_cnt;
  logic [7:0]       pins_prev;
  logic [2:0]       last_cause;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic             cold_pend;

  // Reset source decode, pin, undervoltage and select resets have priority over watchdog expiry and pin wake
  wire sel_bad      = (pin_sel != PIN_SEL_PA7) && (pin_sel != PIN_SEL_RESET);
  wire sel_reset    = sel_bad && (sel_bad_cnt == SEL_LAST) && i_slow_osc_tick;
  wire pin_reset    = !i_ext_reset_pin_n || i_undervoltage_reset || sel_reset;
  wire sleeping     = (mode == RSWL_SLEEP);
  wire wdt_run_rst  = i_watchdog_expire && !sleeping && !pin_reset;
  wire wdt_warm     = i_watchdog_expire && sleeping && !pin_reset;
  wire cold_reset   = pin_reset || wdt_run_rst;
  wire pin_fall     = |(pins_prev & ~i_port_pins & port_wake_enable);
  wire pin_wake     = sleeping && pin_fall && !cold_reset && !wdt_warm;

  // AXI4-Lite write channel
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  assign o_awready = !aw_held && !o_bvalid;
  assign o_wready  = !w_held && !o_bvalid;
  wire aw_fire     = i_awvalid && o_awready;
  wire w_fire      = i_wvalid && o_wready;
  wire have_aw     = aw_held || aw_fire;
  wire have_w      = w_held || w_fire;
  wire wr_go       = have_aw && have_w;
  wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : i_awaddr;
  wire [31:0]       wr_dat  = w_held ? w_data : i_wdata;
  wire [3:0]        wr_stb  = w_held ? w_strb : i_wstrb;
  wire wr_lane0     = wr_go && wr_stb[0];
  wire wr_flags     = wr_lane0 && (wr_addr == OFS_FLAGS);
  wire wr_wake      = wr_lane0 && (wr_addr == OFS_WAKE_EN);
  wire wr_ctrl      = wr_lane0 && (wr_addr == OFS_CTRL);
  wire wr_pdata     = wr_lane0 && (wr_addr == OFS_PORT_DATA);
  wire wr_pdir      = wr_lane0 && (wr_addr == OFS_PORT_DIR);
  wire wr_psel      = wr_lane0 && (wr_addr == OFS_PIN_SEL);
  wire wr_istat     = wr_lane0 && (wr_addr == OFS_IRQ_STAT);
  wire wr_imask     = wr_lane0 && (wr_addr == OFS_IRQ_MASK);
  wire wr_known     = (wr_addr == OFS_FLAGS) || (wr_addr == OFS_WAKE_EN)
                   || (wr_addr == OFS_CTRL) || (wr_addr == OFS_PORT_DATA)
                   || (wr_addr == OFS_PORT_DIR) || (wr_addr == OFS_PIN_SEL)
                   || (wr_addr == OFS_CAUSE) || (wr_addr == OFS_IRQ_STAT)
                   || (wr_addr == OFS_IRQ_MASK) || (wr_addr == OFS_CORE);
  wire halt_req     = wr_ctrl && wr_dat[CTRL_HALT_BIT] && (mode == RSWL_RUN);
  wire wdt_kick     = wr_ctrl && wr_dat[CTRL_WDT_KICK_BIT];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= '0;
      w_data   <= '0;
      w_strb   <= '0;
      o_bvalid <= 1'b0;
      o_bresp  <= 2'b00;
    end else begin
      if (wr_go) begin
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp  <= wr_known ? 2'b00 : 2'b10;
      end else begin
        if (aw_fire) begin
          aw_held <= 1'b1;
          aw_addr <= i_awaddr;
        end
        if (w_fire) begin
          w_held <= 1'b1;
          w_data <= i_wdata;
          w_strb <= i_wstrb;
        end
        if (o_bvalid && i_bready) begin
          o_bvalid <= 1'b0;
        end
      end
    end
  end

  // AXI4-Lite read channel
  assign o_arready = !o_rvalid;
  wire rd_go       = i_arvalid && o_arready;
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = '0;
    unique case (i_araddr)
      OFS_FLAGS:     rd_mux = {30'h0, powerdown_flag, timeout_flag};
      OFS_WAKE_EN:   rd_mux = {24'h0, port_wake_enable};
      OFS_CTRL:      rd_mux = {29'h0, timer_run, 1'b0, 1'b0};
      OFS_PORT_DATA: rd_mux = {24'h0, port_data};
      OFS_PORT_DIR:  rd_mux = {24'h0, port_dir};
      OFS_PIN_SEL:   rd_mux = {27'h0, pin_sel};
      OFS_CAUSE:     rd_mux = {29'h0, last_cause};
      OFS_IRQ_STAT:  rd_mux = {29'h0, irq_stat};
      OFS_IRQ_MASK:  rd_mux = {29'h0, irq_mask};
      OFS_CORE:      rd_mux = {21'h0, stack_ptr, pc_low_byte};
      default:       rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rvalid <= 1'b0;
      o_rdata  <= '0;
      o_rresp  <= 2'b00;
    end else if (rd_go) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_mux;
      o_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // Reset flags, mode, per-reset register defaults
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      timeout_flag     <= 1'b0;
      powerdown_flag   <= 1'b0;
      mode             <= RSWL_RUN;
      port_wake_enable <= WAKE_EN_RST;
      port_data        <= PORT_DATA_RST;
      port_dir         <= PORT_DIR_RST;
      pin_sel          <= PIN_SEL_RST;
      int_enable       <= 1'b0;
      timer_run        <= 1'b0;
      pc_low_byte      <= PC_LOW_RST;
      stack_ptr        <= SP_TOP;
      startup_cnt      <= '0;
      last_cause       <= 3'h1;
      cold_pend        <= 1'b1;
    end else begin
      cold_pend <= 1'b0;
      if (cold_reset) begin
        mode             <= RSWL_RUN;
        port_wake_enable <= WAKE_EN_RST;
        port_data        <= PORT_DATA_RST;
        port_dir         <= PORT_DIR_RST;
        pin_sel          <= PIN_SEL_RST;
        int_enable       <= 1'b0;
        timer_run        <= 1'b0;
        pc_low_byte      <= PC_LOW_RST;
        stack_ptr        <= SP_TOP;
        cold_pend        <= 1'b1;
        last_cause       <= wdt_run_rst ? 3'h3 : 3'h2;
        if (wdt_run_rst) begin
          timeout_flag <= 1'b1;
        end
      end else if (wdt_warm) begin
        pc_low_byte    <= PC_LOW_RST;
        stack_ptr      <= SP_ZERO;
        timeout_flag   <= 1'b1;
        powerdown_flag <= 1'b1;
        startup_cnt    <= '0;
        mode           <= RSWL_STARTUP;
        last_cause     <= 3'h4;
      end else begin
        unique case (mode)
          RSWL_RUN: begin
            if (halt_req) begin
              mode           <= RSWL_SLEEP;
              powerdown_flag <= 1'b1;
              timeout_flag   <= 1'b0;
            end
          end
          RSWL_SLEEP: begin
            if (pin_wake) begin
              mode <= RSWL_RUN;
            end
          end
          RSWL_STARTUP: begin
            startup_cnt <= startup_cnt + 5'd1;
            if (startup_cnt == STARTUP_LAST) begin
              mode <= RSWL_RUN;
            end
          end
          default: mode <= RSWL_RUN;
        endcase
        if (wr_flags) begin
          timeout_flag   <= wr_dat[FLAG_TIMEOUT_BIT];
          powerdown_flag <= wr_dat[FLAG_POWERDOWN_BIT];
        end
        if (wr_wake) begin
          port_wake_enable <= wr_dat[7:0] & WAKE_EN_MASK;
        end
        if (wr_pdata) begin
          port_data <= wr_dat[7:0];
        end
        if (wr_pdir) begin
          port_dir <= wr_dat[7:0];
        end
        if (wr_psel) begin
          pin_sel <= wr_dat[4:0];
        end
        if (wr_ctrl) begin
          timer_run <= wr_dat[CTRL_TMR_RUN_BIT];
        end
        if (wr_imask) begin
          int_enable <= |wr_dat[IRQ_W-1:0];
        end
      end
    end
  end

  // Watchdog counter and timer prescaler
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      watchdog_counter <= '0;
      prescaler        <= '0;
    end else begin
      if (cold_reset || wdt_warm || wdt_kick || halt_req) begin
        watchdog_counter <= '0;
      end else begin
        watchdog_counter <= watchdog_counter + 1'b1;
      end
      if (cold_reset || !timer_run) begin
        prescaler <= '0;
      end else if (!sleeping) begin
        prescaler <= prescaler + 8'd1;
      end
    end
  end

  // Invalid select counter on slow oscillator ticks, pin history
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sel_bad_cnt <= '0;
      pins_prev   <= 8'hFF;
    end else begin
      pins_prev <= i_port_pins;
      if (!sel_bad || sel_reset) begin
        sel_bad_cnt <= '0;
      end else if (i_slow_osc_tick && sel_bad_cnt != SEL_LAST) begin
        sel_bad_cnt <= sel_bad_cnt + 2'd1;
      end
    end
  end

  // Sticky interrupt status, write one to clear, set wins
  wire [IRQ_W-1:0] irq_ev = {pin_wake, wdt_warm, cold_reset};
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_istat ? wr_dat[IRQ_W-1:0] : '0)) | irq_ev;
      if (wr_imask) begin
        irq_mask <= wr_dat[IRQ_W-1:0];
      end
    end
  end

  assign o_irq              = |(irq_stat & irq_mask);
  assign o_core_reset       = cold_pend;
  assign o_sys_clk_en       = (mode == RSWL_RUN);
  assign o_pc_low_byte      = pc_low_byte;
  assign o_stack_ptr        = stack_ptr;
  assign o_int_enable       = int_enable;
  assign o_timer_run        = timer_run;
  assign o_watchdog_counter = watchdog_counter;
  assign o_port_data        = port_data;
  assign o_port_dir         = port_dir;
endmodule

// *** design/rswl_pkg.sv ***
// Package: register map, reset values and timing constants of the reset and wake block
package rswl_pkg;
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned ADDR_W      = 8;

  // Register byte addresses
  localparam logic [7:0] OFS_FLAGS     = 8'h00;
  localparam logic [7:0] OFS_WAKE_EN   = 8'h04;
  localparam logic [7:0] OFS_CTRL      = 8'h08;
  localparam logic [7:0] OFS_PORT_DATA = 8'h0C;
  localparam logic [7:0] OFS_PORT_DIR  = 8'h10;
  localparam logic [7:0] OFS_PIN_SEL   = 8'h14;
  localparam logic [7:0] OFS_CAUSE     = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;
  localparam logic [7:0] OFS_CORE      = 8'h24;

  // Field positions
  localparam int unsigned FLAG_TIMEOUT_BIT   = 0;
  localparam int unsigned FLAG_POWERDOWN_BIT = 1;
  localparam int unsigned CTRL_HALT_BIT      = 0;
  localparam int unsigned CTRL_WDT_KICK_BIT  = 1;
  localparam int unsigned CTRL_TMR_RUN_BIT   = 2;

  // Reset values, wake enable mask and valid pin select codes
  localparam logic [7:0] WAKE_EN_MASK   = 8'h27;
  localparam logic [7:0] WAKE_EN_RST    = 8'h00;
  localparam logic [7:0] PORT_DATA_RST  = 8'hFF;
  localparam logic [7:0] PORT_DIR_RST   = 8'hFF;
  localparam logic [7:0] PC_LOW_RST     = 8'h00;
  localparam logic [4:0] PIN_SEL_PA7    = 5'h00;
  localparam logic [4:0] PIN_SEL_RESET  = 5'h15;
  localparam logic [4:0] PIN_SEL_RST    = 5'h00;
  localparam logic [2:0] SP_ZERO        = 3'h0;
  localparam logic [2:0] SP_TOP         = 3'h7;

  // Timing
  localparam int unsigned STARTUP_WAIT_CYC = 16;
  localparam int unsigned SLOW_OSC_MIN_CYC = 2;
  localparam int unsigned SLOW_OSC_MAX_CYC = 3;

  // Interrupt status bits
  localparam int unsigned IRQ_COLD_BIT  = 0;
  localparam int unsigned IRQ_WARM_BIT  = 1;
  localparam int unsigned IRQ_WAKE_BIT  = 2;
  localparam int unsigned IRQ_W         = 3;

  typedef enum logic [1:0] {
    RSWL_RUN,
    RSWL_SLEEP,
    RSWL_STARTUP
  } rswl_mode_e;
endpackage

// *** verification/rswl_props.sv ***
// Checker of reset, wake and bus timing at the block ports
module rswl_props
  import rswl_pkg::*;
#(
  parameter int unsigned WDT_W = 16
) (
  input wire logic              i_clk,
  input wire logic              i_resetn,
  input wire logic              i_ext_reset_pin_n,
  input wire logic              i_undervoltage_reset,
  input wire logic              i_watchdog_expire,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic              i_awvalid,
  input wire logic              o_awready,
  input wire logic [31:0]       i_wdata,
  input wire logic [3:0]        i_wstrb,
  input wire logic              i_wvalid,
  input wire logic              o_wready,
  input wire logic [1:0]        o_bresp,
  input wire logic              o_bvalid,
  input wire logic              i_bready,
  input wire logic              i_arvalid,
  input wire logic              o_arready,
  input wire logic [31:0]       o_rdata,
  input wire logic              o_rvalid,
  input wire logic              i_rready,
  input wire logic              o_core_reset,
  input wire logic              o_sys_clk_en,
  input wire logic [7:0]        o_pc_low_byte,
  input wire logic [2:0]        o_stack_ptr,
  input wire logic              o_int_enable,
  input wire logic              o_timer_run,
  input wire logic [WDT_W-1:0]  o_watchdog_counter,
  input wire logic [7:0]        o_port_data,
  input wire logic [7:0]        o_port_dir
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire cold = !i_ext_reset_pin_n || i_undervoltage_reset;
  wire halt = i_awvalid && o_awready && i_wvalid && o_wready && i_awaddr == OFS_CTRL
              && i_wstrb[0] && i_wdata[CTRL_HALT_BIT];
  sequence s_warm;
    i_watchdog_expire && !o_sys_clk_en && !cold && !o_core_reset;
  endsequence
  sequence s_wait;
    !o_sys_clk_en [*8] ##1 !o_sys_clk_en [*8];
  endsequence
  AST_COLD_PORTS: assert property (
    o_core_reset |-> o_port_data == PORT_DATA_RST && o_port_dir == PORT_DIR_RST
    && o_pc_low_byte == PC_LOW_RST) else $error("cold reset port or pc value wrong");
  AST_COLD_CORE: assert property (
    o_core_reset |-> !o_int_enable && !o_timer_run && o_watchdog_counter == '0)
    else $error("cold reset left interrupt, timer or watchdog active");
  AST_PIN_RESET: assert property (
    $fell(i_ext_reset_pin_n) || $rose(i_undervoltage_reset) |=> o_core_reset)
    else $error("pin or undervoltage reset not applied");
  AST_WDT_RUN: assert property (
    i_watchdog_expire && o_sys_clk_en && !o_core_reset |=> o_core_reset)
    else $error("running watchdog expiry gave no full reset");
  AST_WARM_KEEP: assert property (
    s_warm |=> o_stack_ptr == SP_ZERO && o_pc_low_byte == PC_LOW_RST
    && o_port_data == $past(o_port_data) && !o_core_reset)
    else $error("warm watchdog reset changed the wrong state");
  AST_STARTUP: assert property (
    s_warm |=> s_wait ##1 o_sys_clk_en) else $error("start-up wait length wrong");
  AST_HALT: assert property (
    halt && !cold && !i_watchdog_expire |-> ##[1:3] !o_sys_clk_en)
    else $error("halt did not stop the system clock");
  AST_BHOLD: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
  AST_RHOLD: assert property (
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("read answer dropped");
  AST_RLAT: assert property (
    i_arvalid && o_arready |=> o_rvalid) else $error("read answer late");
endmodule

bind rswl_top rswl_props #(.WDT_W(WDT_W)) u_props (.*);

// *** verification/rswl_buttons.sv ***
// Model of the external reset switch and wake push buttons
module rswl_buttons (
  input  wire logic       i_press_reset,
  input  wire logic [7:0] i_press_btn,
  output logic            o_pin_n,
  output logic [7:0]      o_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released contacts rest high on their pull-ups, a press pulls low
  assign o_pin_n = !i_press_reset;
  assign o_pins  = ~i_press_btn;
endmodule

// *** verification/rswl_top_bench.sv ***
// Bus-driven test sequence for the reset and wake block
module rswl_top_bench
  import rswl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk, i_resetn, i_undervoltage_reset, i_watchdog_expire, i_slow_osc_tick;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, press_rst;
  logic [7:0]  i_awaddr, i_araddr, press_btn;
  logic [31:0] i_wdata, rd;
  logic [3:0]  i_wstrb;
  logic [1:0]  o_bresp, o_rresp, rsp;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_core_reset, o_sys_clk_en;
  logic        o_int_enable, o_timer_run, o_irq;
  logic [31:0] o_rdata;
  logic [7:0]  o_pc_low_byte, o_port_data, o_port_dir;
  logic [2:0]  o_stack_ptr;
  logic [15:0] o_watchdog_counter;
  wire         i_ext_reset_pin_n;
  wire  [7:0]  i_port_pins;
  int          miscompares, compares, k;

  rswl_top #(.WDT_W(16)) dut (.*);
  rswl_buttons u_btn (.i_press_reset(press_rst), .i_press_btn(press_btn),
                      .o_pin_n(i_ext_reset_pin_n), .o_pins(i_port_pins));

  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic fail_to;
    miscompares++;
    $display("mismatch wait expected answer seen timeout");
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    logic ta, tw, tb;
    n = 0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= 4'hF;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do begin
      @(negedge i_clk);
      ta = i_awvalid && o_awready;
      tw = i_wvalid && o_wready;
      tb = o_bvalid;
      rsp = o_bresp;
      @(posedge i_clk);
      if (ta) i_awvalid <= 1'h0;
      if (tw) i_wvalid <= 1'h0;
      n++;
    end while (!tb && n < 40);
    i_bready <= 1'h0;
    if (!tb) fail_to();
    chk("bresp", 32'(er), 32'(rsp));
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int n;
    logic ta, tb;
    n = 0;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do begin
      @(negedge i_clk);
      ta = i_arvalid && o_arready;
      tb = o_rvalid;
      rd = o_rdata;
      rsp = o_rresp;
      @(posedge i_clk);
      if (ta) i_arvalid <= 1'h0;
      n++;
    end while (!tb && n < 40);
    i_rready <= 1'h0;
    if (!tb) fail_to();
    chk($sformatf("reg %h", a), e, rd);
    chk("rresp", 32'(er), 32'(rsp));
  endtask
  task automatic wait_en(input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_sys_clk_en !== lvl && n < 40);
    if (o_sys_clk_en !== lvl) fail_to();
  endtask
  task automatic pulse_wdt;
    @(posedge i_clk);
    i_watchdog_expire <= 1'h1;
    @(posedge i_clk);
    i_watchdog_expire <= 1'h0;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic tick;
    @(posedge i_clk);
    i_slow_osc_tick <= 1'h1;
    @(posedge i_clk);
    i_slow_osc_tick <= 1'h0;
  endtask
  task automatic irq_is(input logic e);
    @(negedge i_clk);
    chk("irq", 32'(e), 32'(o_irq));
  endtask

  initial begin
    {i_resetn, i_undervoltage_reset, i_watchdog_expire, i_slow_osc_tick, press_rst} = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_wstrb, press_btn} = '0;
    {i_awaddr, i_araddr, i_wdata, miscompares, compares} = '0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'h1;
    rc(OFS_FLAGS, 32'h0000_0000);
    rc(OFS_WAKE_EN, 32'h0000_0000);
    rc(OFS_PORT_DATA, 32'h0000_00FF);
    rc(OFS_PORT_DIR, 32'h0000_00FF);
    rc(OFS_CORE, 32'h0000_0700);
    rc(OFS_CAUSE, 32'h0000_0001);
    rc(8'h30, 32'h0000_0000, 2'h2);
    wr(OFS_WAKE_EN, 32'h0000_00FF);
    rc(OFS_WAKE_EN, 32'h0000_0027);
    $display("test power_on done");
    for (k = 0; k < 2; k++) begin
      wr(OFS_FLAGS, k == 0 ? 32'h0000_0001 : 32'h0000_0002);
      wr(OFS_PORT_DATA, 32'h0000_0000);
      wr(OFS_WAKE_EN, 32'h0000_0027);
      wr(OFS_PIN_SEL, 32'h0000_0015);
      @(posedge i_clk);
      if (k == 0) press_rst <= 1'h1;
      else i_undervoltage_reset <= 1'h1;
      repeat (3) @(posedge i_clk);
      press_rst <= 1'h0;
      i_undervoltage_reset <= 1'h0;
      repeat (3) @(posedge i_clk);
      rc(OFS_FLAGS, k == 0 ? 32'h0000_0001 : 32'h0000_0002);
      rc(OFS_PORT_DATA, 32'h0000_00FF);
      rc(OFS_WAKE_EN, 32'h0000_0000);
      rc(OFS_CAUSE, 32'h0000_0002);
    end
    $display("test pin_reset done");
    wr(OFS_FLAGS, 32'h0000_0002);
    wr(OFS_PORT_DATA, 32'h0000_0000);
    pulse_wdt();
    rc(OFS_FLAGS, 32'h0000_0003);
    rc(OFS_PORT_DATA, 32'h0000_00FF);
    rc(OFS_CAUSE, 32'h0000_0003);
    $display("test watchdog_run done");
    wr(OFS_PORT_DATA, 32'h0000_005A);
    wr(OFS_WAKE_EN, 32'h0000_0027);
    wr(OFS_IRQ_MASK, 32'h0000_0007);
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    irq_is(1'h0);
    wr(OFS_CTRL, 32'h0000_0001);
    wait_en(1'h0);
    pulse_wdt();
    wait_en(1'h1);
    rc(OFS_FLAGS, 32'h0000_0003);
    rc(OFS_PORT_DATA, 32'h0000_005A);
    rc(OFS_CORE, 32'h0000_0000);
    rc(OFS_WAKE_EN, 32'h0000_0027);
    rc(OFS_CAUSE, 32'h0000_0004);
    rc(OFS_IRQ_STAT, 32'h0000_0002);
    irq_is(1'h1);
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    irq_is(1'h0);
    wr(OFS_IRQ_MASK, 32'h0000_0007);
    irq_is(1'h1);
    wr(OFS_IRQ_STAT, 32'h0000_0002);
    irq_is(1'h0);
    $display("test warm_wake done");
    wr(OFS_CTRL, 32'h0000_0001);
    wait_en(1'h0);
    @(posedge i_clk);
    press_btn <= 8'h08;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk("clk_en", 32'h0000_0000, 32'(o_sys_clk_en));
    @(posedge i_clk);
    press_btn <= 8'h28;
    wait_en(1'h1);
    @(posedge i_clk);
    press_btn <= 8'h00;
    $display("test pin_wake done");
    wr(OFS_PIN_SEL, 32'h0000_0003);
    tick();
    tick();
    rc(OFS_PIN_SEL, 32'h0000_0003);
    tick();
    repeat (3) @(posedge i_clk);
    rc(OFS_PIN_SEL, 32'h0000_0000);
    rc(OFS_CAUSE, 32'h0000_0002);
    $display("test bad_select done");
    wr(OFS_FLAGS, 32'h0000_0000);
    wr(OFS_PIN_SEL, 32'h0000_0015);
    @(posedge i_clk);
    press_rst <= 1'h1;
    pulse_wdt();
    press_rst <= 1'h0;
    repeat (3) @(posedge i_clk);
    rc(OFS_FLAGS, 32'h0000_0000);
    rc(OFS_CAUSE, 32'h0000_0002);
    $display("test priority done");
    wr(OFS_FLAGS, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0004);
    rc(OFS_CTRL, 32'h0000_0004);
    @(posedge i_clk);
    i_resetn <= 1'h0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'h1;
    rc(OFS_FLAGS, 32'h0000_0000);
    rc(OFS_CTRL, 32'h0000_0000);
    rc(OFS_CORE, 32'h0000_0700);
    rc(OFS_CAUSE, 32'h0000_0001);
    $display("test power_on_again done");
    complete_run();
  end
endmodule
